// ===== tiv_pkg.sv
// package: register map, field layouts and request carrier for the invalidate block
package tiv_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   // register byte addresses
   localparam logic [7:0] OFF_INV_LO = 8'h00;
   localparam logic [7:0] OFF_INV_HI = 8'h04;
   localparam logic [7:0] OFF_CTRL = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0c;
   localparam logic [7:0] OFF_ID = 8'h10;
   // control register fields
   localparam int CTRL_WIDE_BIT = 0;
   localparam int CTRL_SECURE_BIT = 1;
   localparam int CTRL_HYPERVISOR_CONTEXT_FLAG_BIT = 2;
   localparam int CTRL_MONITOR_CONTEXT_FLAG_BIT = 3;
   localparam int CTRL_GRAN_LSB = 4;
   localparam int CTRL_VIRTUAL_MACHINE_TAG_LSB = 8;
   localparam int VIRTUAL_MACHINE_TAG_W = 16;
   localparam int BANK_W = 8;
   localparam int CTRL_BANK_LSB = 24;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   // wide layout fields
   localparam int WIDE_ADDR_MSB = 43;
   localparam int VA_LSB = 12;
   localparam int VA_TOP = 55;
   // narrow layout field
   localparam int NARROW_VA_MSB = 31;
   // granule encodings
   localparam logic [1:0] GRAN_4K = 2'h0;
   localparam logic [1:0] GRAN_16K = 2'h1;
   localparam logic [1:0] GRAN_64K = 2'h2;
   // status fields
   localparam int STAT_ISSUED_BIT = 0;
   localparam int STAT_DROP_BIT = 1;
   localparam int STAT_CNT_LSB = 16;
   localparam int CNT_W = 16;

   typedef struct packed {
      logic [63:0] va;
      logic [BANK_W-1:0] bank;
      logic [VIRTUAL_MACHINE_TAG_W-1:0] virtual_machine_tag;
      logic virtual_machine_tag_match;
      logic secure;
      logic any_address_space_tag;
      logic incl_global;
      logic last_level;
   } tiv_req_s;
endpackage

// ===== tiv_reqmem.sv
// small memory holding the latched low word of either layout, registered read
module tiv_reqmem #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 2
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // write port
   input wire logic we,
   input wire logic [$clog2(DEPTH)-1:0] waddr,
   input wire logic [WIDTH-1:0] wdata,
   // read port
   input wire logic [$clog2(DEPTH)-1:0] raddr,
   output logic [WIDTH-1:0] rdata
);
   logic [WIDTH-1:0] mem_r [DEPTH];

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         for (int i = 0; i < DEPTH; i++)
            mem_r[i] <= '0;
      end
      else if (we)
      begin
         mem_r[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
         rdata <= '0;
      else
         rdata <= mem_r[raddr];
   end
endmodule

// ===== tiv_top.sv
// write-only invalidate-by-address (any address space, last level) maintenance register
module tiv_top #(
   parameter bit STAGE_ONE = 1'b1,
   parameter logic [7:0] ID_TAG = 8'h5a // arbitrary value
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // register port
   input wire logic [tiv_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [tiv_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [tiv_pkg::DATA_W-1:0] reg_rdata,
   // request to the translation cache
   output logic inv_valid,
   output tiv_pkg::tiv_req_s inv_req
);
   typedef enum logic [1:0] {ST_IDLE, ST_HAVE_LO, ST_ISSUE} tiv_state_e;

   tiv_state_e state_r;
   logic [31:0] ctrl_r;
   logic [31:0] hi_r;
   logic issued_r;
   logic drop_r;
   logic [tiv_pkg::CNT_W-1:0] cnt_r;
   logic [31:0] lo_q;
   logic lo_we;
   logic [63:0] raw_va;
   logic [63:0] va_nxt;
   logic wide;
   logic bad_bank;

   function automatic logic hit(input logic [tiv_pkg::ADDR_W-1:0] a,
                                input logic [7:0] off);
      hit = (a == off);
   endfunction

   assign wide = ctrl_r[tiv_pkg::CTRL_WIDE_BIT];
   assign bad_bank = ctrl_r[tiv_pkg::CTRL_HYPERVISOR_CONTEXT_FLAG_BIT] | ctrl_r[tiv_pkg::CTRL_MONITOR_CONTEXT_FLAG_BIT];
   assign lo_we = reg_wr && hit(reg_addr, tiv_pkg::OFF_INV_LO) && STAGE_ONE;

   // low word store; read data registered inside
   tiv_reqmem #(.WIDTH(32), .DEPTH(2)) u_mem (
      .clk(clk),
      .rstn(rstn),
      .we(lo_we),
      .waddr(1'b0),
      .wdata(reg_wdata),
      .raddr(1'b0),
      .rdata(lo_q)
   );

   // control register: layout, security, bank identity, granule, tag
   always_ff @(posedge clk)
   begin
      if (!rstn)
         ctrl_r <= tiv_pkg::CTRL_RST;
      else if (reg_wr && hit(reg_addr, tiv_pkg::OFF_CTRL))
         ctrl_r <= reg_wdata;
   end

   // upper word, only meaningful in wide layout; narrow ignores it
   always_ff @(posedge clk)
   begin
      if (!rstn)
         hi_r <= '0;
      else if (reg_wr && hit(reg_addr, tiv_pkg::OFF_INV_HI) && wide)
         hi_r <= reg_wdata;
   end

   // sequencing: a low-word write launches unless the state is ST_HAVE_LO; both layouts wait for the memory read
   always_ff @(posedge clk)
   begin
      if (!rstn)
         state_r <= ST_IDLE;
      else
      begin
         case (state_r)
            ST_IDLE:
               if (lo_we)
                  state_r <= ST_HAVE_LO;
            ST_HAVE_LO:
               state_r <= ST_ISSUE;
            ST_ISSUE:
               state_r <= lo_we ? ST_HAVE_LO : ST_IDLE;
            default:
               state_r <= ST_IDLE;
         endcase
      end
   end

   // the upper word is consumed by one launch; a lone low write then is zero-extended
   logic hi_used_r;
   always_ff @(posedge clk)
   begin
      if (!rstn)
         hi_used_r <= 1'b1;
      else if (reg_wr && hit(reg_addr, tiv_pkg::OFF_INV_HI) && wide)
         hi_used_r <= 1'b0;
      else if (state_r == ST_ISSUE)
         hi_used_r <= 1'b1;
   end

   // assemble the address from the selected layout
   always_comb
   begin
      raw_va = '0;
      if (wide)
      begin
         // upper word applies when written before the low word or in the cycle right after it
         raw_va[tiv_pkg::VA_TOP:tiv_pkg::VA_LSB] =
            {(hi_used_r ? 12'h000 : hi_r[11:0]), lo_q};
      end
      else
      begin
         raw_va[tiv_pkg::NARROW_VA_MSB:tiv_pkg::VA_LSB] =
            lo_q[tiv_pkg::NARROW_VA_MSB:tiv_pkg::VA_LSB];
      end
      va_nxt = raw_va;
      case (ctrl_r[tiv_pkg::CTRL_GRAN_LSB +: 2])
         tiv_pkg::GRAN_64K: va_nxt[15:12] = 4'h0;
         tiv_pkg::GRAN_16K: va_nxt[13:12] = 2'h0;
         default: va_nxt = raw_va;
      endcase
      if (wide)
         va_nxt[63:56] = {8{raw_va[tiv_pkg::VA_TOP]}};
   end

   // request output: one pulse per launch on a permitted bank, once the stored low word is readable
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         inv_valid <= 1'b0;
         inv_req <= '0;
      end
      else
      begin
         inv_valid <= (state_r == ST_ISSUE) && !bad_bank;
         if (state_r == ST_ISSUE)
         begin
            inv_req.va <= va_nxt;
            inv_req.bank <= ctrl_r[tiv_pkg::CTRL_BANK_LSB +: tiv_pkg::BANK_W];
            inv_req.virtual_machine_tag <= ctrl_r[tiv_pkg::CTRL_VIRTUAL_MACHINE_TAG_LSB +: tiv_pkg::VIRTUAL_MACHINE_TAG_W];
            // secure banks never compare the machine tag
            inv_req.virtual_machine_tag_match <= !ctrl_r[tiv_pkg::CTRL_SECURE_BIT];
            inv_req.secure <= ctrl_r[tiv_pkg::CTRL_SECURE_BIT];
            inv_req.any_address_space_tag <= 1'b1;
            inv_req.incl_global <= 1'b1;
            inv_req.last_level <= 1'b1;
         end
      end
   end

   // status: launches issued, last launch dropped on a forbidden bank
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         issued_r <= 1'b0;
         drop_r <= 1'b0;
         cnt_r <= '0;
      end
      else if (state_r == ST_ISSUE)
      begin
         issued_r <= !bad_bank;
         drop_r <= bad_bank;
         cnt_r <= cnt_r + (bad_bank ? '0 : tiv_pkg::CNT_W'(1));
      end
   end

   // read port: invalidate words read as zero
   always_ff @(posedge clk)
   begin
      if (!rstn)
         reg_rdata <= '0;
      else if (reg_rd)
      begin
         if (hit(reg_addr, tiv_pkg::OFF_CTRL))
            reg_rdata <= ctrl_r;
         else if (hit(reg_addr, tiv_pkg::OFF_STATUS))
            reg_rdata <= {cnt_r, 14'h0000, drop_r, issued_r};
         else if (hit(reg_addr, tiv_pkg::OFF_ID))
            reg_rdata <= {23'h000000, STAGE_ONE, ID_TAG};
         else
            reg_rdata <= '0;
      end
      else
         reg_rdata <= '0;
   end
endmodule

// ===== tiv_props.sv
// concurrent checks on the ports of the invalidate block
module tiv_props (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   // request
   input wire logic inv_valid,
   input wire tiv_pkg::tiv_req_s inv_req
);
   logic [31:0] ctl_r;
   logic lo_wr;
   assign lo_wr = reg_wr && reg_addr == tiv_pkg::OFF_INV_LO;
   // shadow of the control word
   always_ff @(posedge clk)
   begin
      if (!rstn)
         ctl_r <= tiv_pkg::CTRL_RST;
      else if (reg_wr && reg_addr == tiv_pkg::OFF_CTRL)
         ctl_r <= reg_wdata;
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   sequence s_lo_ok;
      lo_wr && ctl_r[3:2] == 2'h0;
   endsequence
   property p_launch; s_lo_ok |-> ##3 inv_valid; endproperty
   a_launch: assert property (p_launch) else $error("no request");
   property p_cause; inv_valid |-> $past(lo_wr, 3); endproperty
   a_cause: assert property (p_cause) else $error("stray request");
   property p_pulse; inv_valid |=> !inv_valid; endproperty
   a_pulse: assert property (p_pulse) else $error("long request");
   property p_rd; !reg_rd || reg_addr < 8'h08 |=> reg_rdata == 32'h0; endproperty
   a_rd: assert property (p_rd) else $error("read not zero");
   property p_nar; inv_valid && !ctl_r[0] |-> inv_req.va[63:32] == 32'h0; endproperty
   a_nar: assert property (p_nar) else $error("narrow upper");
   property p_ext; inv_valid && ctl_r[0] |-> inv_req.va[63:56] == {8{inv_req.va[55]}}; endproperty
   a_ext: assert property (p_ext) else $error("no extension");
   property p_gran;
      inv_valid && ctl_r[0] |-> (ctl_r[5:4] != 2'h2 || inv_req.va[15:12] == 4'h0)
         && (ctl_r[5:4] != 2'h1 || inv_req.va[13:12] == 2'h0);
   endproperty
   a_gran: assert property (p_gran) else $error("granule bits");
   property p_qual;
      inv_valid |-> inv_req.any_address_space_tag && inv_req.incl_global && inv_req.last_level;
   endproperty
   a_qual: assert property (p_qual) else $error("qualifier");
   property p_tags;
      inv_valid |-> inv_req.secure == ctl_r[1] && inv_req.virtual_machine_tag_match == !ctl_r[1]
         && (ctl_r[1] || inv_req.virtual_machine_tag == ctl_r[23:8]) && inv_req.bank == ctl_r[31:24];
   endproperty
   a_tags: assert property (p_tags) else $error("bank tags");
endmodule
bind tiv_top tiv_props u_props (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .reg_rdata, .inv_valid, .inv_req);

// ===== test_tiv_top.sv
// self-checking bench for the invalidate block
module test_tiv_top;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [31:0] ctl;
      logic wh;
      logic [31:0] hi;
      logic [31:0] lo;
      logic [63:0] va;
   } tiv_row_s;
   localparam logic [7:0] LO = tiv_pkg::OFF_INV_LO;
   localparam logic [7:0] CT = tiv_pkg::OFF_CTRL;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic inv_valid;
   tiv_pkg::tiv_req_s inv_req;
   logic [31:0] d;
   int n_errors = 0;
   int cmp_count = 0;
   int npul = 0;
   int n0;
   int cyc = 0;
   // control, high word written or not, high, low, expected address
   tiv_row_s rows [4] = '{
      '{32'h00000002, 1'b1, 32'hffffffff, 32'hdeadbfff, 64'h0000_0000_dead_b000},
      '{32'h07123401, 1'b1, 32'hfffff123, 32'h89abcdef, 64'h0012_389a_bcde_f000},
      '{32'h3cbeef23, 1'b1, 32'h00000800, 32'h0000ffff, 64'hff80_0000_0fff_0000},
      '{32'h00000011, 1'b0, 32'h0, 32'hffffffff, 64'h0000_0fff_ffff_c000}};
   tiv_top uut (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .inv_valid, .inv_req);
   always #20 clk = ~clk;
   task automatic end_sim;
      if (n_errors == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cyc++;
      if (inv_valid === 1'b1)
         npul++;
      if (cyc == 3000)
      begin
         n_errors++;
         end_sim();
      end
   end
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string nm);
      cmp_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("Error %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_rd <= 1'b0;
      reg_wr <= 1'b1;
   endtask
   task automatic idle(input int n);
      repeat (n)
      begin
         @(posedge clk);
         reg_wr <= 1'b0;
         reg_rd <= 1'b0;
      end
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      idle(1);
      #1;
      d = reg_rdata;
   endtask
   initial
   begin
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      foreach (rows[i])
      begin
         wr(CT, rows[i].ctl);
         if (rows[i].wh)
            wr(tiv_pkg::OFF_INV_HI, rows[i].hi);
         n0 = npul;
         wr(LO, rows[i].lo);
         idle(6);
         chk(64'(npul - n0), 64'h1, "count");
         chk(inv_req.va, rows[i].va, "va");
         chk(64'(inv_req.secure), 64'(rows[i].ctl[1]), "secure");
         chk(64'(inv_req.virtual_machine_tag_match), 64'(!rows[i].ctl[1]), "virtual_machine_tag match");
      end
      rd(LO);
      chk(64'(d), 64'h0, "read low");
      rd(tiv_pkg::OFF_INV_HI);
      chk(64'(d), 64'h0, "read high");
      rd(8'h3c);
      chk(64'(d), 64'h0, "read unmapped");
      rd(tiv_pkg::OFF_ID);
      chk(64'(d[8]), 64'h1, "stage one");
      // hypervisor and monitor banks are suppressed
      for (int k = 2; k < 4; k++)
      begin
         wr(CT, 32'h1 << k);
         n0 = npul;
         wr(LO, 32'h1000);
         idle(6);
         chk(64'(npul - n0), 64'h0, "suppressed");
      end
      rd(tiv_pkg::OFF_STATUS);
      chk(64'(d), 64'h0000_0000_0004_0002, "status");
      wr(CT, 32'h0);
      n0 = npul;
      wr(LO, 32'h0000_3fff);
      idle(1);
      wr(LO, 32'h0000_2abc);
      idle(6);
      chk(64'(npul - n0), 64'h2, "two requests");
      chk(inv_req.va, 64'h2000, "last va");
      // reset in mid-run returns the bank to narrow layout
      wr(CT, 32'h1);
      idle(1);
      rstn <= 1'b0;
      idle(3);
      rstn <= 1'b1;
      rd(CT);
      chk(64'(d), 64'h0, "ctrl after reset");
      wr(LO, 32'hffff_f000);
      idle(6);
      chk(inv_req.va, 64'hffff_f000, "va after reset");
      end_sim();
   end
endmodule
